/* rtl/rot_consts.svh */
// constants for the rotate instruction unit
`ifndef ROT_CONSTS_SVH
`define ROT_CONSTS_SVH

// ------------------------------------------------------------
// instruction word fields
// ------------------------------------------------------------
`define ROT_INSTR_W        16
`define ROT_OPC_MSB        15
`define ROT_OPC_LSB        9
`define ROT_DEST_BIT       8
`define ROT_ADDR_MSB       7
`define ROT_ADDR_LSB       0

// ------------------------------------------------------------
// opcodes (upper seven bits of the word)
// ------------------------------------------------------------
`define ROT_OPC_RIGHT_CARRY 7'h0c
`define ROT_OPC_LEFT_NOCARRY 7'h11

// ------------------------------------------------------------
// destination select values
// ------------------------------------------------------------
`define ROT_DEST_WORKING   1'h0
`define ROT_DEST_FILE      1'h1

// ------------------------------------------------------------
// arithmetic status bit positions
// ------------------------------------------------------------
`define ROT_FLAG_C         0
`define ROT_FLAG_DC        1
`define ROT_FLAG_Z         2
`define ROT_FLAG_OV        3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ROT_WORKING_RST    8'h00
`define ROT_FLAGS_RST      4'h0
`define ROT_INSTR_RST      16'h0000
`define ROT_DATA_RST       8'h00

`endif

/* rtl/rot_if.sv */
// carrier between the sequencer and the rotate datapath
`timescale 1ns/1ps
interface rot_if;
  import rot_pkg::*;

  rot_op_type op;
  logic [7:0] operand;
  logic       carry_in;
  logic [7:0] result;
  logic       carry_out;

  modport alu
  (
    input  op,
    input  operand,
    input  carry_in,
    output result,
    output carry_out
  );

  modport core
  (
    output op,
    output operand,
    output carry_in,
    input  result,
    input  carry_out
  );
endinterface : rot_if

/* rtl/rot_pkg.sv */
// types shared by the rotate instruction unit
package rot_pkg;

  typedef enum logic [3:0] {
    phase_decode  = 4'b0001,
    phase_read    = 4'b0010,
    phase_execute = 4'b0100,
    phase_write   = 4'b1000
  } phase_type;

  typedef enum logic [2:0] {
    op_none                   = 3'b001,
    rotate_right_via_carry_op = 3'b010,
    rotate_left_no_carry_op   = 3'b100
  } rot_op_type;

endpackage : rot_pkg

/* rtl/rot_shifter.sv */
// combinational rotate datapath for both rotate opcodes
`timescale 1ns/1ps
module rot_shifter
  import rot_pkg::*;
(
  rot_if.alu sh
);

  always_comb
  begin
    sh.result    = sh.operand;
    sh.carry_out = sh.carry_in;
    unique case (sh.op)
      rotate_right_via_carry_op:
      begin
        sh.result    = {sh.carry_in, sh.operand[7:1]};
        sh.carry_out = sh.operand[0];
      end
      rotate_left_no_carry_op:
      begin
        sh.result    = {sh.operand[6:0], sh.operand[7]};
        sh.carry_out = sh.carry_in;
      end
      op_none:
      begin
        sh.result    = sh.operand;
        sh.carry_out = sh.carry_in;
      end
      default:
      begin
        sh.result    = sh.operand;
        sh.carry_out = sh.carry_in;
      end
    endcase
  end

endmodule : rot_shifter

/* rtl/rotate_instruction_unit.sv */
// four-phase rotate instruction unit: sequencer, operand path, destination write
// ------------------------------------------------------------
// Summary of operation
// - the right rotate moves each bit down one, bit 0 goes to carry and old carry enters bit 7.
// - destination bit 0 writes the result to the working register, 1 writes it to the file.
// - the right rotate changes only carry among the status bits; zero, dc and overflow hold.
// - the operand is read from the file address in the low byte, in one four-phase cycle.
// ------------------------------------------------------------
`timescale 1ns/1ps
`include "rot_consts.svh"

module rotate_instruction_unit
  import rot_pkg::*;
(
  input  wire logic                    mclk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    ce_i,
  input  wire logic                    instr_valid_i,
  input  wire logic [`ROT_INSTR_W-1:0] instr_i,
  output logic                         instr_ready_o,
  output logic [7:0]                   file_addr_o,
  output logic                         file_re_o,
  input  wire logic [7:0]              file_rdata_i,
  output logic                         file_we_o,
  output logic [7:0]                   file_wdata_o,
  input  wire logic                    working_wr_i,
  input  wire logic [7:0]              working_wdata_i,
  output logic [7:0]                   working_register_o,
  input  wire logic                    flags_wr_i,
  input  wire logic [3:0]              flags_wdata_i,
  output logic [3:0]                   flags_o,
  output logic                         busy_o
);

  phase_type             phase_reg;
  phase_type             phase_next;
  rot_op_type            op_reg;
  rot_op_type            op_next;
  logic [`ROT_INSTR_W-1:0] instr_reg;
  logic [7:0]            operand_reg;
  logic [7:0]            result_reg;
  logic                  carry_out_reg;
  logic [7:0]            working_reg;
  logic [3:0]            flags_reg;
  logic                  active;
  logic                  dest_file;
  logic                  take;

  rot_if sh_if ();

  // ------------------------------------------------------------
  // phase sequencer
  // ------------------------------------------------------------
  always_comb
  begin
    phase_next = phase_reg;
    unique case (phase_reg)
      phase_decode:  phase_next = take ? phase_read : phase_decode;
      phase_read:    phase_next = phase_execute;
      phase_execute: phase_next = phase_write;
      phase_write:   phase_next = phase_decode;
      default:       phase_next = phase_decode;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      phase_reg <= phase_decode;
    else if (ce_i)
      phase_reg <= phase_next;
  end

  assign take          = (phase_reg == phase_decode) && instr_valid_i;
  assign instr_ready_o = (phase_reg == phase_decode);
  assign busy_o        = (phase_reg != phase_decode);

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  always_comb
  begin
    unique case (instr_i[`ROT_OPC_MSB:`ROT_OPC_LSB])
      `ROT_OPC_RIGHT_CARRY:  op_next = rotate_right_via_carry_op;
      `ROT_OPC_LEFT_NOCARRY: op_next = rotate_left_no_carry_op;
      default:               op_next = op_none;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      instr_reg <= `ROT_INSTR_RST;
      op_reg    <= op_none;
    end
    else if (ce_i && take)
    begin
      instr_reg <= instr_i;
      op_reg    <= op_next;
    end
  end

  assign active    = (op_reg != op_none);
  assign dest_file = (instr_reg[`ROT_DEST_BIT] == `ROT_DEST_FILE);

  // ------------------------------------------------------------
  // operand read
  // ------------------------------------------------------------
  assign file_addr_o = instr_reg[`ROT_ADDR_MSB:`ROT_ADDR_LSB];
  assign file_re_o   = (phase_reg == phase_read) && active;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      operand_reg <= `ROT_DATA_RST;
    else if (ce_i && file_re_o)
      operand_reg <= file_rdata_i;
  end

  // ------------------------------------------------------------
  // execute
  // ------------------------------------------------------------
  assign sh_if.op       = op_reg;
  assign sh_if.operand  = operand_reg;
  assign sh_if.carry_in = flags_reg[`ROT_FLAG_C];

  rot_shifter u_shifter
  (
    .sh (sh_if.alu)
  );

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      result_reg    <= `ROT_DATA_RST;
      carry_out_reg <= 1'h0;
    end
    else if (ce_i && (phase_reg == phase_execute) && active)
    begin
      result_reg    <= sh_if.result;
      carry_out_reg <= sh_if.carry_out;
    end
  end

  // ------------------------------------------------------------
  // destination write
  // ------------------------------------------------------------
  assign file_we_o    = ce_i && (phase_reg == phase_write) && active && dest_file;
  assign file_wdata_o = result_reg;

  // the rotate result wins over a concurrent load from elsewhere in the core
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      working_reg <= `ROT_WORKING_RST;
    else if (ce_i && (phase_reg == phase_write) && active && !dest_file)
      working_reg <= result_reg;
    else if (ce_i && working_wr_i)
      working_reg <= working_wdata_i;
  end

  assign working_register_o = working_reg;

  // ------------------------------------------------------------
  // status bits
  // ------------------------------------------------------------
  // only carry follows the right rotate; an outside write still sets the other bits
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flags_reg <= `ROT_FLAGS_RST;
    else if (ce_i)
    begin
      if (flags_wr_i)
        flags_reg <= flags_wdata_i;
      if ((phase_reg == phase_write) && (op_reg == rotate_right_via_carry_op))
        flags_reg[`ROT_FLAG_C] <= carry_out_reg;
    end
  end

  assign flags_o = flags_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_issue;
    ce_i && take && (op_next != op_none);
  endsequence

  sequence s_write_right;
    (phase_reg == phase_write) && (op_reg == rotate_right_via_carry_op);
  endsequence

  sequence s_write_left;
    (phase_reg == phase_write) && (op_reg == rotate_left_no_carry_op);
  endsequence

  AST_RIGHT_RESULT: assert property (
    s_write_right |-> result_reg == {flags_reg[`ROT_FLAG_C], operand_reg[7:1]})
    else $error("right rotate result wrong");

  AST_RIGHT_CARRY: assert property (
    (s_write_right ##0 ce_i) |=> flags_reg[`ROT_FLAG_C] == $past(operand_reg[0]))
    else $error("right rotate carry wrong");

  AST_DEST_FILE: assert property (
    (phase_reg == phase_write && active && ce_i && dest_file)
      |-> file_we_o && file_wdata_o == result_reg)
    else $error("file destination not written");

  AST_DEST_WORKING: assert property (
    (phase_reg == phase_write && active && ce_i && !dest_file)
      |-> !file_we_o ##1 working_register_o == $past(result_reg))
    else $error("working destination not written");

  AST_FLAGS_HOLD: assert property (
    (s_write_right ##0 (ce_i && !flags_wr_i))
      |=> flags_o[3:1] == $past(flags_o[3:1]))
    else $error("right rotate touched other flags");

  AST_READ_ADDR: assert property (
    s_issue |=> file_re_o && file_addr_o == $past(instr_i[7:0]))
    else $error("operand read from wrong address");

  AST_ONE_CYCLE: assert property (
    s_issue ##1 ce_i[*2] |=> phase_reg == phase_write && active)
    else $error("instruction did not reach write phase");

  AST_LEFT_RESULT: assert property (
    s_write_left |-> result_reg == {operand_reg[6:0], operand_reg[7]})
    else $error("left rotate result wrong");

  AST_LEFT_FLAGS: assert property (
    (s_write_left ##0 (ce_i && !flags_wr_i)) |=> $stable(flags_o))
    else $error("left rotate changed flags");

endmodule : rotate_instruction_unit

/* test/rotate_instruction_unit_tb.sv */
// self-checking testbench for the rotate instruction unit
`timescale 1ns/1ps
`include "rot_consts.svh"

module rotate_instruction_unit_tb;
  import rot_pkg::*;

  // ----------------------------------------------------------
  // signals
  // ----------------------------------------------------------
  logic        mclk_i;
  logic        rst_n_i;
  logic        ce_i;
  logic        instr_valid_i;
  logic [15:0] instr_i;
  logic        instr_ready_o;
  logic [7:0]  file_addr_o;
  logic        file_re_o;
  logic [7:0]  file_rdata_i;
  logic        file_we_o;
  logic [7:0]  file_wdata_o;
  logic        working_wr_i;
  logic [7:0]  working_wdata_i;
  logic [7:0]  working_register_o;
  logic        flags_wr_i;
  logic [3:0]  flags_wdata_i;
  logic [3:0]  flags_o;
  logic        busy_o;
  logic [7:0]  file_mem [256];
  int          we_cnt;
  int          err_total;
  int          checked;

  rotate_instruction_unit i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .instr_ready_o(instr_ready_o),
    .file_addr_o(file_addr_o), .file_re_o(file_re_o), .file_rdata_i(file_rdata_i),
    .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .working_wr_i(working_wr_i),
    .working_wdata_i(working_wdata_i), .working_register_o(working_register_o),
    .flags_wr_i(flags_wr_i), .flags_wdata_i(flags_wdata_i), .flags_o(flags_o),
    .busy_o(busy_o));

  // ----------------------------------------------------------
  // clock and file register model
  // ----------------------------------------------------------
  always #20 mclk_i = ~mclk_i;

  assign file_rdata_i = file_mem[file_addr_o];

  always @(posedge mclk_i)
  begin
    if (file_we_o && ce_i)
    begin
      file_mem[file_addr_o] <= file_wdata_o;
      we_cnt <= we_cnt + 1;
    end
  end

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // preload working register and flags, then run one instruction and judge it
  task automatic run(input logic [6:0] opc, input logic d, input logic [7:0] a,
                     input logic [7:0] f, input logic [3:0] fl);
    logic [7:0] r;
    logic [3:0] fe;
    logic       rot;
    int         n;
    int         w0;
    r = f;
    fe = fl;
    rot = (opc == `ROT_OPC_RIGHT_CARRY) || (opc == `ROT_OPC_LEFT_NOCARRY);
    if (opc == `ROT_OPC_RIGHT_CARRY)
    begin
      r = {fl[0], f[7:1]};
      fe[0] = f[0];
    end
    else if (opc == `ROT_OPC_LEFT_NOCARRY)
      r = {f[6:0], f[7]};
    file_mem[a] = f;
    @(posedge mclk_i);
    flags_wr_i      <= 1'h1;
    flags_wdata_i   <= fl;
    working_wr_i    <= 1'h1;
    working_wdata_i <= 8'h5a;
    @(posedge mclk_i);
    flags_wr_i    <= 1'h0;
    working_wr_i  <= 1'h0;
    instr_valid_i <= 1'h1;
    instr_i       <= {opc, d, a};
    w0 = we_cnt;
    @(posedge mclk_i);
    instr_valid_i <= 1'h0;
    #1;
    check(file_re_o, rot);
    check(file_addr_o, a);
    n = 0;
    while (busy_o && n < 10)
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (busy_o)
    begin
      err_total++;
      wrap_up();
    end
    check(n, 3);
    check(we_cnt - w0, rot && d);
    if (opc == `ROT_OPC_RIGHT_CARRY)
      check(flags_o, fe);
    else
      check(flags_o, fl);
    if (!rot || d)
    begin
      check(working_register_o, 8'h5a);
      check(file_mem[a], (rot ? r : f));
    end
    else
    begin
      check(working_register_o, r);
      check(file_mem[a], f);
    end
    if (opc == `ROT_OPC_RIGHT_CARRY)
      check((d ? file_mem[a] : working_register_o), {fl[0], f[7:1]});
    else if (opc == `ROT_OPC_LEFT_NOCARRY)
      check((d ? file_mem[a] : working_register_o), {f[6:0], f[7]});
  endtask : run

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic test_reset;
    check(instr_ready_o, 1'h1);
    check(busy_o, 1'h0);
    check(file_we_o, 1'h0);
    check(flags_o, `ROT_FLAGS_RST);
    check(working_register_o, `ROT_WORKING_RST);
  endtask : test_reset

  task automatic test_right;
    logic [3:0] i;
    for (i = 0; i < 8; i++)
      run(`ROT_OPC_RIGHT_CARRY, i[1], 8'hff - i, (i[2] ? 8'h01 : 8'he6),
          {~i[0], i[2], i[1] ^ i[0], i[0]});
  endtask : test_right

  task automatic test_left;
    logic [2:0] i;
    for (i = 0; i < 4; i++)
      run(`ROT_OPC_LEFT_NOCARRY, i[1], 8'h00 + i, (i[0] ? 8'heb : 8'h80),
          (i[0] ? 4'hf : 4'h0));
  endtask : test_left

  task automatic test_other;
    run(7'h33, 1'h1, 8'h40, 8'h81, 4'h9);
    run(7'h33, 1'h0, 8'h41, 8'h7e, 4'h6);
  endtask : test_other

  // enable dropped in the read and execute phases of a right rotate to the working register
  task automatic test_stall;
    file_mem[8'h20] = 8'h03;
    @(posedge mclk_i);
    flags_wr_i      <= 1'h1;
    flags_wdata_i   <= 4'h0;
    working_wr_i    <= 1'h1;
    working_wdata_i <= 8'h11;
    @(posedge mclk_i);
    flags_wr_i    <= 1'h0;
    working_wr_i  <= 1'h0;
    instr_valid_i <= 1'h1;
    instr_i       <= {`ROT_OPC_RIGHT_CARRY, `ROT_DEST_WORKING, 8'h20};
    @(posedge mclk_i);
    instr_valid_i <= 1'h0;
    ce_i          <= 1'h0;
    repeat (3) @(posedge mclk_i);
    #1;
    check(busy_o, 1'h1);
    check(file_re_o, 1'h1);
    @(posedge mclk_i);
    ce_i <= 1'h1;
    @(posedge mclk_i);
    ce_i <= 1'h0;
    repeat (2) @(posedge mclk_i);
    #1;
    check(file_re_o, 1'h0);
    check(working_register_o, 8'h11);
    check(flags_o, 4'h0);
    @(posedge mclk_i);
    ce_i <= 1'h1;
    repeat (2) @(posedge mclk_i);
    #1;
    check(busy_o, 1'h0);
    check(working_register_o, 8'h01);
    check(flags_o, 4'h1);
  endtask : test_stall

  // rotate write and outside loads of flags and working register meet at one edge
  task automatic test_overlap;
    file_mem[8'h30] = 8'h9c;
    @(posedge mclk_i);
    flags_wr_i    <= 1'h1;
    flags_wdata_i <= 4'h1;
    @(posedge mclk_i);
    flags_wr_i    <= 1'h0;
    instr_valid_i <= 1'h1;
    instr_i       <= {`ROT_OPC_RIGHT_CARRY, `ROT_DEST_WORKING, 8'h30};
    @(posedge mclk_i);
    instr_valid_i <= 1'h0;
    repeat (2) @(posedge mclk_i);
    flags_wr_i      <= 1'h1;
    flags_wdata_i   <= 4'hb;
    working_wr_i    <= 1'h1;
    working_wdata_i <= 8'h77;
    @(posedge mclk_i);
    flags_wr_i   <= 1'h0;
    working_wr_i <= 1'h0;
    #1;
    check(flags_o, 4'ha);
    check(flags_o[0], 1'h0);
    check(working_register_o, 8'hce);
  endtask : test_overlap

  // reset pulled in the middle of a left rotate to the file, then a clean run
  task automatic test_mid_reset;
    int w0;
    file_mem[8'h50] = 8'h01;
    @(posedge mclk_i);
    instr_valid_i <= 1'h1;
    instr_i       <= {`ROT_OPC_LEFT_NOCARRY, `ROT_DEST_FILE, 8'h50};
    w0 = we_cnt;
    @(posedge mclk_i);
    instr_valid_i <= 1'h0;
    @(posedge mclk_i);
    rst_n_i <= 1'h0;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    #1;
    check(busy_o, 1'h0);
    check(instr_ready_o, 1'h1);
    check(working_register_o, `ROT_WORKING_RST);
    check(flags_o, `ROT_FLAGS_RST);
    check(we_cnt - w0, 0);
    check(file_mem[8'h50], 8'h01);
    run(`ROT_OPC_LEFT_NOCARRY, 1'h1, 8'h50, 8'h01, 4'h0);
  endtask : test_mid_reset

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    mclk_i          = 1'h0;
    rst_n_i         = 1'h0;
    ce_i            = 1'h1;
    instr_valid_i   = 1'h0;
    instr_i         = 16'h0000;
    working_wr_i    = 1'h0;
    working_wdata_i = 8'h00;
    flags_wr_i      = 1'h0;
    flags_wdata_i   = 4'h0;
    we_cnt          = 0;
    err_total       = 0;
    checked         = 0;
    for (int k = 0; k < 256; k++)
      file_mem[k] = 8'h00;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    #1;
    test_reset();
    test_right();
    test_left();
    test_other();
    test_stall();
    test_overlap();
    test_mid_reset();
    wrap_up();
  end
endmodule : rotate_instruction_unit_tb
